// ---- logic/dvje_defs.vh ----
// Register offsets, field positions and reset values of the DAC volume and jack enable bank.
`ifndef DVJE_DEFS_VH
`define DVJE_DEFS_VH

// Register offsets on the 7-bit control address.
`define DVJE_ADDR_LEFT_VOL 7'h0B
`define DVJE_ADDR_RIGHT_VOL 7'h0C
`define DVJE_ADDR_JACK_EN 7'h0D
`define DVJE_ADDR_JACK_CTRL 7'h30
`define DVJE_ADDR_PWR_EN 7'h31
`define DVJE_ADDR_STATUS 7'h32

// Volume register fields.
`define DVJE_VOL_APPLY_BIT 8
`define DVJE_VOL_CODE_MSB 7
`define DVJE_VOL_CODE_LSB 0

// Jack-detect driver enable fields.
`define DVJE_JACK_HIGH_MSB 7
`define DVJE_JACK_HIGH_LSB 4
`define DVJE_JACK_LOW_MSB 3
`define DVJE_JACK_LOW_LSB 0

// Jack control fields.
`define DVJE_JCTL_ENABLE_BIT 0
`define DVJE_JCTL_SEL_MSB 2
`define DVJE_JCTL_SEL_LSB 1

// Driver enable bit order, shared by every driver group.
`define DVJE_DRV_HEADPHONE 0
`define DVJE_DRV_SPEAKER 1
`define DVJE_DRV_AUX_TWO 2
`define DVJE_DRV_AUX_ONE 3

// Status fields.
`define DVJE_STAT_LEVEL_BIT 4
`define DVJE_STAT_RMUTE_BIT 5
`define DVJE_STAT_LMUTE_BIT 6

// Reset values and special codes.
`define DVJE_RST_VOL 9'h0FF
`define DVJE_RST_JACK_EN 9'h000
`define DVJE_RST_JACK_CTRL 9'h000
`define DVJE_RST_PWR_EN 9'h000
`define DVJE_CODE_MUTE 8'h00
`define DVJE_CODE_FULL 8'hFF

`endif

// ---- logic/dvje_top.v ----
// Control bank for DAC volume with synchronised L/R update and jack-driven driver enables.
// How it works
// - Right write with apply clear only stores code in shadow; active code unchanged.
// - Right write with apply set activates new right and pending left together.
// - Apply bit is write-only, acts at the write, reads back as zero.
// - Attenuation code zero mutes the channel digitally.
// - Code one is -127.0dB; each step up gives 0.5dB less attenuation.
// - Code all ones gives no attenuation; code FE gives 0.5dB.
// - Right volume register resets to 0x0FF, zero attenuation.
// - Detection enabled and selected input high enables drivers in bits 4 to 7.
// - High group order: headphones, speakers, aux two, aux one.
// - Detection enabled and input low enables bits 0 to 3, same order.
// - Left write with apply set activates left and pending right; else only stores.
//
// Our own choice: the strobed register port.
`default_nettype none
`include "dvje_defs.vh"
module dvje_top (
    input wire clock, // 250 MHz core clock.
    input wire reset_n, // Synchronous reset, active low.
    input wire clk_en, // Freezes all state while low.
    input wire [6:0] reg_addr, // Register address.
    input wire [8:0] reg_wdata, // Register write data.
    input wire reg_wr, // Write strobe, one cycle.
    input wire reg_rd, // Read strobe, one cycle.
    output reg [8:0] reg_rdata_ff, // Read data, valid the cycle after the strobe.
    input wire [2:0] jack_sense_in, // Jack detection inputs, synchronous.
    output wire [7:0] left_dac_attenuation, // Active left code.
    output wire left_dac_mute, // Left channel muted.
    output wire [7:0] left_atten_half_db, // Left attenuation in half-dB.
    output wire [7:0] right_dac_attenuation, // Active right code.
    output wire right_dac_mute, // Right channel muted.
    output wire [7:0] right_atten_half_db, // Right attenuation in half-dB.
    output reg [3:0] driver_enable_ff, // Headphone, speaker, aux two, aux one.
    output reg jack_level_ff // Level of the selected jack input.
);

    // Address match, used by every write and read decode below.
    function hit;
        input [6:0] addr;
        input [6:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Reset values at register width; each field takes its own slice.
    localparam [8:0] JACK_EN_RST = `DVJE_RST_JACK_EN;
    localparam [8:0] JACK_CTRL_RST = `DVJE_RST_JACK_CTRL;
    localparam [8:0] PWR_RST = `DVJE_RST_PWR_EN;

    // Stored settings.
    reg [3:0] jack_high_driver_enables_ff;
    reg [3:0] jack_low_driver_enables_ff;
    reg jack_detect_on_ff;
    reg [1:0] jack_select_ff;
    reg [3:0] power_enables_ff;

    // Next values of the stored settings.
    reg [3:0] nxt_jack_high;
    reg [3:0] nxt_jack_low;
    reg nxt_jack_on;
    reg [1:0] nxt_jack_sel;
    reg [3:0] nxt_power;

    // Decoded strobes.
    wire wr_left;
    wire wr_right;
    wire wr_jack_en;
    wire wr_jack_ctrl;
    wire wr_power;
    wire volume_apply;
    wire left_volume_apply;
    wire right_volume_apply;

    // Per-channel wiring for the two volume channels; index 0 is left.
    wire [1:0] chan_store;
    wire [7:0] chan_shadow [0:1];
    wire [7:0] chan_active [0:1];
    wire [1:0] chan_mute;
    wire [7:0] chan_atten [0:1];

    // Driver decision wires.
    reg sel_level;
    reg [3:0] jack_group;
    reg [3:0] nxt_drivers;
    reg [8:0] nxt_rdata;

    // Write decode; the strobe is qualified here once for all registers.
    assign wr_left = reg_wr && hit(reg_addr, `DVJE_ADDR_LEFT_VOL);
    assign wr_right = reg_wr && hit(reg_addr, `DVJE_ADDR_RIGHT_VOL);
    assign wr_jack_en = reg_wr && hit(reg_addr, `DVJE_ADDR_JACK_EN);
    assign wr_jack_ctrl = reg_wr && hit(reg_addr, `DVJE_ADDR_JACK_CTRL);
    assign wr_power = reg_wr && hit(reg_addr, `DVJE_ADDR_PWR_EN);

    // apply acts at write
    // The apply bit feeds a one-cycle strobe only and is never stored, so a
    // later plain write cannot re-trigger an update by accident.
    assign left_volume_apply = wr_left && reg_wdata[`DVJE_VOL_APPLY_BIT];
    assign right_volume_apply = wr_right && reg_wdata[`DVJE_VOL_APPLY_BIT];

    // left apply both
    // Either apply strobe moves both channels, giving a glitch-free balance change.
    assign volume_apply = left_volume_apply || right_volume_apply;

    assign chan_store[0] = wr_left;
    assign chan_store[1] = wr_right;

    // Both channels share one structure; only the store strobe differs.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            dvje_vol_chan u_chan (
                .clock(clock),
                .reset_n(reset_n),
                .clk_en(clk_en),
                .store_stb(chan_store[ch]),
                .store_code(reg_wdata[`DVJE_VOL_CODE_MSB:`DVJE_VOL_CODE_LSB]),
                .apply_stb(volume_apply),
                .shadow_ff(chan_shadow[ch]),
                .active_ff(chan_active[ch]),
                .mute_ff(chan_mute[ch]),
                .atten_ff(chan_atten[ch])
            );
        end
    endgenerate

    // Channel outputs come straight from the channel flip-flops.
    assign left_dac_attenuation = chan_active[0];
    assign left_dac_mute = chan_mute[0];
    assign left_atten_half_db = chan_atten[0];
    assign right_dac_attenuation = chan_active[1];
    assign right_dac_mute = chan_mute[1];
    assign right_atten_half_db = chan_atten[1];

    // Next values of the plain read/write settings.
    always @* begin
        nxt_jack_high = jack_high_driver_enables_ff;
        nxt_jack_low = jack_low_driver_enables_ff;
        nxt_jack_on = jack_detect_on_ff;
        nxt_jack_sel = jack_select_ff;
        nxt_power = power_enables_ff;
        if (wr_jack_en) begin
            nxt_jack_high = reg_wdata[`DVJE_JACK_HIGH_MSB:`DVJE_JACK_HIGH_LSB];
            nxt_jack_low = reg_wdata[`DVJE_JACK_LOW_MSB:`DVJE_JACK_LOW_LSB];
        end
        if (wr_jack_ctrl) begin
            nxt_jack_on = reg_wdata[`DVJE_JCTL_ENABLE_BIT];
            nxt_jack_sel = reg_wdata[`DVJE_JCTL_SEL_MSB:`DVJE_JCTL_SEL_LSB];
        end
        if (wr_power) begin
            nxt_power = reg_wdata[3:0];
        end
    end

    // Settings registers; reset wins over the clock enable.
    always @(posedge clock) begin
        if (!reset_n) begin
            jack_high_driver_enables_ff <= JACK_EN_RST[`DVJE_JACK_HIGH_MSB:`DVJE_JACK_HIGH_LSB];
            jack_low_driver_enables_ff <= JACK_EN_RST[`DVJE_JACK_LOW_MSB:`DVJE_JACK_LOW_LSB];
            jack_detect_on_ff <= JACK_CTRL_RST[`DVJE_JCTL_ENABLE_BIT];
            jack_select_ff <= JACK_CTRL_RST[`DVJE_JCTL_SEL_MSB:`DVJE_JCTL_SEL_LSB];
            power_enables_ff <= PWR_RST[3:0];
        end else if (clk_en) begin
            jack_high_driver_enables_ff <= nxt_jack_high;
            jack_low_driver_enables_ff <= nxt_jack_low;
            jack_detect_on_ff <= nxt_jack_on;
            jack_select_ff <= nxt_jack_sel;
            power_enables_ff <= nxt_power;
        end
    end

    // Select the jack input; a select value past the last input reads as low,
    // which keeps the low-level group in charge rather than floating.
    always @* begin
        case (jack_select_ff)
            2'h0: sel_level = jack_sense_in[0];
            2'h1: sel_level = jack_sense_in[1];
            2'h2: sel_level = jack_sense_in[2];
            default: sel_level = 1'h0;
        endcase
    end

    // Choose the jack group and merge it with the power settings.
    always @* begin
        if (sel_level) begin
            jack_group = jack_high_driver_enables_ff[3:0];
        end else begin
            jack_group = jack_low_driver_enables_ff;
        end
        if (jack_detect_on_ff) begin
            nxt_drivers = power_enables_ff | jack_group;
        end else begin
            nxt_drivers = power_enables_ff;
        end
    end

    // Driver enables are registered so the analog side sees no decode glitches.
    always @(posedge clock) begin
        if (!reset_n) begin
            driver_enable_ff <= 4'h0;
            jack_level_ff <= 1'h0;
        end else if (clk_en) begin
            driver_enable_ff <= nxt_drivers;
            jack_level_ff <= sel_level;
        end
    end

    // Read mux; unmapped addresses return zero and reserved bits read as zero.
    always @* begin
        nxt_rdata = 9'h000;
        if (hit(reg_addr, `DVJE_ADDR_LEFT_VOL)) begin
            nxt_rdata = {1'h0, chan_shadow[0]};
        end else if (hit(reg_addr, `DVJE_ADDR_RIGHT_VOL)) begin
            nxt_rdata = {1'h0, chan_shadow[1]};
        end else if (hit(reg_addr, `DVJE_ADDR_JACK_EN)) begin
            nxt_rdata = {1'h0, jack_high_driver_enables_ff[3:0], jack_low_driver_enables_ff};
        end else if (hit(reg_addr, `DVJE_ADDR_JACK_CTRL)) begin
            nxt_rdata = {6'h00, jack_select_ff, jack_detect_on_ff};
        end else if (hit(reg_addr, `DVJE_ADDR_PWR_EN)) begin
            nxt_rdata = {5'h00, power_enables_ff};
        end else if (hit(reg_addr, `DVJE_ADDR_STATUS)) begin
            nxt_rdata = {2'h0, chan_mute[0], chan_mute[1], jack_level_ff, driver_enable_ff};
        end
    end

    // Read data stands for exactly the cycle after the strobe, then returns to zero.
    always @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata_ff <= 9'h000;
        end else if (clk_en) begin
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end else begin
                reg_rdata_ff <= 9'h000;
            end
        end
    end

endmodule // dvje_top
`default_nettype wire

// ---- logic/dvje_vol_chan.v ----
// One DAC volume channel: shadow code, active code and its decoded attenuation.
`default_nettype none
`include "dvje_defs.vh"
module dvje_vol_chan (
    input wire clock, // Core clock.
    input wire reset_n, // Synchronous reset, active low.
    input wire clk_en, // Freezes all state while low.
    input wire store_stb, // Write of this channel's volume register.
    input wire [7:0] store_code, // Attenuation code carried by that write.
    input wire apply_stb, // Any volume write with its apply bit set.
    output reg [7:0] shadow_ff, // Pending code, as read back by software.
    output reg [7:0] active_ff, // Code in use by the DAC channel.
    output reg mute_ff, // Digital mute of the channel.
    output reg [7:0] atten_ff // Attenuation in half-dB steps.
);

    // Reset code held at register width; only the code field is kept here.
    localparam [8:0] RST_VOL = `DVJE_RST_VOL;

    reg [7:0] nxt_shadow;
    reg [7:0] nxt_active;

    // A write with apply set must activate its own new code, so bypass the shadow.
    always @* begin
        nxt_shadow = store_stb ? store_code : shadow_ff;
        nxt_active = apply_stb ? nxt_shadow : active_ff;
    end

    // Active code and its decode move together, so mute and gain never disagree.
    always @(posedge clock) begin
        if (!reset_n) begin
            shadow_ff <= RST_VOL[`DVJE_VOL_CODE_MSB:`DVJE_VOL_CODE_LSB];
            active_ff <= RST_VOL[`DVJE_VOL_CODE_MSB:`DVJE_VOL_CODE_LSB];
            mute_ff <= 1'h0;
            atten_ff <= 8'h00;
        end else if (clk_en) begin
            shadow_ff <= nxt_shadow;
            active_ff <= nxt_active;
            mute_ff <= (nxt_active == `DVJE_CODE_MUTE);
            atten_ff <= `DVJE_CODE_FULL - nxt_active;
        end
    end

endmodule // dvje_vol_chan
`default_nettype wire

// ---- testbench/dvje_top_properties.sv ----
// Concurrent checks on the volume and jack enable bank ports.
`default_nettype none
`include "dvje_defs.vh"
module dvje_properties (
    input wire logic clock, // Core clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic clk_en, // Clock enable.
    input wire logic [6:0] reg_addr, // Register address.
    input wire logic [8:0] reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    input wire logic [8:0] reg_rdata_ff, // Read data.
    input wire logic [7:0] left_dac_attenuation, // Active left code.
    input wire logic [7:0] right_dac_attenuation, // Active right code.
    input wire logic right_dac_mute, // Right mute.
    input wire logic [7:0] right_atten_half_db // Right attenuation.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Volume writes, split by channel and apply bit.
    sequence s_right_store;
        clk_en && reg_wr && reg_addr == 7'h0C && !reg_wdata[8];
    endsequence
    sequence s_right_apply;
        clk_en && reg_wr && reg_addr == 7'h0C && reg_wdata[8];
    endsequence
    sequence s_left_apply;
        clk_en && reg_wr && reg_addr == 7'h0B && reg_wdata[8];
    endsequence
    property p_right_hold;
        s_right_store |=> $stable(right_dac_attenuation);
    endproperty
    property p_right_apply;
        s_right_apply |=> right_dac_attenuation == $past(reg_wdata[7:0]);
    endproperty
    property p_pair;
        s_right_store ##1 s_left_apply |=> right_dac_attenuation == $past(reg_wdata[7:0], 2);
    endproperty
    property p_left_hold;
        s_right_store |=> $stable(left_dac_attenuation);
    endproperty
    property p_apply_reads_zero;
        clk_en && reg_rd && reg_addr == 7'h0C |=> reg_rdata_ff[8] == 1'b0;
    endproperty
    property p_mute;
        right_dac_mute == (right_dac_attenuation == 8'h00);
    endproperty
    property p_step;
        right_atten_half_db == 8'hFF - right_dac_attenuation;
    endproperty
    property p_full;
        right_dac_attenuation == 8'hFF |-> right_atten_half_db == 8'h00;
    endproperty
    property p_reset;
        $rose(reset_n) |-> right_dac_attenuation == 8'hFF && !right_dac_mute;
    endproperty
    a_right_hold: assert property (p_right_hold) else $error("right code moved on store");
    a_left_hold: assert property (p_left_hold) else $error("left code moved on store");
    a_right_apply: assert property (p_right_apply) else $error("right apply wrong");
    a_pair: assert property (p_pair) else $error("pending right not applied");
    a_apply_reads_zero: assert property (p_apply_reads_zero) else $error("apply bit read");
    a_mute: assert property (p_mute) else $error("mute does not follow code");
    a_step: assert property (p_step) else $error("attenuation step wrong");
    a_full: assert property (p_full) else $error("full code attenuates");
    a_reset: assert property (p_reset) else $error("right reset code wrong");
endmodule // dvje_properties
bind dvje_top dvje_properties dvje_properties_i (.clock(clock), .reset_n(reset_n),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .left_dac_attenuation(left_dac_attenuation),
    .right_dac_attenuation(right_dac_attenuation), .right_dac_mute(right_dac_mute),
    .right_atten_half_db(right_atten_half_db));
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the DAC volume and jack enable bank.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic [8:0] reg_wdata = 9'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] jack_sense_in = 3'h0;
    wire [8:0] reg_rdata_ff;
    wire [7:0] l_code, l_att, r_code, r_att;
    wire l_mute, r_mute, jack_level_ff;
    wire [3:0] driver_enable_ff;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Rows: address, write data, expected left and right active codes.
    logic [31:0] rows [7] = '{{7'h0C, 9'h064, 8'hFF, 8'hFF}, {7'h0B, 9'h180, 8'h80, 8'h64},
        {7'h0B, 9'h011, 8'h80, 8'h64}, {7'h0C, 9'h1FE, 8'h11, 8'hFE},
        {7'h0C, 9'h100, 8'h11, 8'h00}, {7'h0C, 9'h1FF, 8'h11, 8'hFF},
        {7'h0C, 9'h101, 8'h11, 8'h01}};
    logic [6:0] a;
    logic [8:0] d;
    logic [7:0] el, er;
    dvje_top dvje_top_i (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .jack_sense_in(jack_sense_in),
        .left_dac_attenuation(l_code), .left_dac_mute(l_mute), .left_atten_half_db(l_att),
        .right_dac_attenuation(r_code), .right_dac_mute(r_mute), .right_atten_half_db(r_att),
        .driver_enable_ff(driver_enable_ff), .jack_level_ff(jack_level_ff));
    // Free-running 250 MHz clock.
    initial forever #2 clock = ~clock;
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] wa, input logic [8:0] wd);
        @(posedge clock);
        reg_addr <= wa;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [6:0] ra);
        @(posedge clock);
        reg_addr <= ra;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic complete_run();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // A hang is cut short well beyond the roughly 80 cycles the run needs.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        #1;
        chk(r_code, 9'h0FF);
        chk(r_att, 9'h000);
        rd(7'h0C);
        chk(reg_rdata_ff, 9'h0FF);
        for (int i = 0; i < 7; i++) begin
            {a, d, el, er} = rows[i];
            wr(a, d);
            chk(l_code, el);
            chk(r_code, er);
            chk(r_mute, er == 8'h00);
            chk(r_att, 9'h0FF - er);
            chk(l_mute, el == 8'h00);
            chk(l_att, 9'h0FF - el);
            rd(a);
            chk(reg_rdata_ff, {1'b0, d[7:0]});
        end
        // Back-to-back pair: right stored, then left applies both.
        @(posedge clock);
        reg_addr <= 7'h0C;
        reg_wdata <= 9'h033;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_addr <= 7'h0B;
        reg_wdata <= 9'h144;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
        chk(r_code, 9'h033);
        chk(l_code, 9'h044);
        // A strobe with the enable low must leave the codes alone.
        @(posedge clock);
        clk_en <= 1'b0;
        wr(7'h0C, 9'h1AA);
        @(posedge clock);
        clk_en <= 1'b1;
        #1;
        chk(r_code, 9'h033);
        rd(7'h7F);
        chk(reg_rdata_ff, 9'h000);
        // Jack groups: high group 5, low group A, detection on input zero.
        wr(7'h0D, 9'h05A);
        wr(7'h31, 9'h000);
        wr(7'h30, 9'h001);
        @(posedge clock);
        jack_sense_in <= 3'h1;
        settle();
        chk(driver_enable_ff, 9'h005);
        chk(jack_level_ff, 9'h001);
        @(posedge clock);
        jack_sense_in <= 3'h0;
        settle();
        chk(driver_enable_ff, 9'h00A);
        rd(7'h0D);
        chk(reg_rdata_ff, 9'h05A);
        wr(7'h30, 9'h000);
        settle();
        chk(driver_enable_ff, 9'h000);
        wr(7'h31, 9'h002);
        settle();
        chk(driver_enable_ff, 9'h002);
        // Input two selected with power on: power and high group add up.
        wr(7'h30, 9'h005);
        @(posedge clock);
        jack_sense_in <= 3'h4;
        settle();
        chk(driver_enable_ff, 9'h007);
        rd(7'h32);
        chk(reg_rdata_ff, 9'h017);
        // Select three has no input behind it, so the low group rules.
        wr(7'h30, 9'h007);
        settle();
        chk(driver_enable_ff, 9'h00A);
        // Second reset in mid-run.
        @(posedge clock);
        reset_n <= 1'b0;
        @(posedge clock);
        reset_n <= 1'b1;
        #1;
        chk(r_code, 9'h0FF);
        rd(7'h0D);
        chk(reg_rdata_ff, 9'h000);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
